// >>> verilog/boot_source_select_fallback.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RL1 - pins 0000 test access, 0110 second card, 1000 octal flash
// RL2 - 0001 quad 24-bit, 0010 quad 32-bit, SD variants, 1010 parallel slave
// RL3 - test access and parallel port are host driven; others device mastered
// RL4 - search limits: octal 8 Gb, quad24 128 Mb, dual-parallel quad24 256 Mb
// RL5 - quad32 4 Gb or 8 Gb dual-parallel; cards 8191 files
// RL6 - load error bumps retry index by one, then soft system reset
// RL7 - no soft reset on errors in test access mode
// RL8 - header, copy, power, integrity and command failures are load errors
// RL9 - fallback only on flash and card sources, same primary device
// RL10 - stacked flash: only lower device until boot completes
// RL11 - read mode, copy loader firmware, then release loader processor
// RL12 - secondary only when named, and never equal to primary
// RL13 - secondary source carries no boot header nor loader firmware
// RL14 - usb secondary image staged at fixed address 5000000 hex
// RL15 - pcie secondary only; endpoint brought up before host delivers
// RL16 - first card controller never primary; may serve as secondary
// RL17 - runtime command rewrites the retry index
// RL18 - no execute in place nor linear quad flash mode
// RL19 - boot mode pins sampled after power-on reset, held
// RL20 - flash search steps 32k from retry index times step
// RL21 - unlisted mode pattern is a boot error, no device
// RL22 - search hitting limit without header signals boot failure
module boot_source_select_fallback (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] mode_pins,
  input wire logic dual_parallel,
  input wire logic probe_done,
  input wire logic probe_header_ok,
  input wire logic fw_copy_done,
  input wire logic err_header,
  input wire logic err_copy,
  input wire logic err_power,
  input wire logic err_integrity,
  input wire logic err_command,
  input wire logic retry_write,
  input wire logic [boot_select_pkg::POS_W-1:0] retry_wdata,
  input wire logic meta_valid,
  input wire logic [3:0] meta_secondary,
  input wire logic boot_complete,
  output logic [3:0] boot_mode,
  output logic [3:0] primary_device,
  output logic slave_boot,
  output logic fallback_enable,
  output logic probe_req,
  output logic [boot_select_pkg::OFFSET_W-1:0] probe_offset,
  output logic [boot_select_pkg::POS_W-1:0] probe_file,
  output logic fw_copy_req,
  output logic loader_release,
  output logic soft_system_reset,
  output logic [boot_select_pkg::POS_W-1:0] image_retry_index,
  output logic boot_error,
  output logic search_exhausted,
  output logic upper_flash_enable,
  output logic secondary_start,
  output logic secondary_reject,
  output logic [3:0] secondary_device,
  output logic secondary_header_expected,
  output logic pcie_endpoint_init,
  output logic [boot_select_pkg::OFFSET_W-1:0] secondary_load_addr
);
  localparam int PW = boot_select_pkg::POS_W;

  // strap synchroniser and capture
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] settle;
  boot_select_pkg::state_e state;
  boot_select_pkg::state_e next_state;
  logic [PW:0] pos;
  logic [PW:0] next_pos;
  logic [PW-1:0] next_index;
  logic booted;

  // decoded view of the held boot mode
  boot_select_pkg::dev_e dec_device;
  logic dec_valid;
  logic dec_slave;
  logic dec_card;
  logic [PW:0] dec_limit;

  boot_mode_decode boot_mode_decode_inst (
    .mode(boot_mode),
    .dual_parallel(dual_parallel),
    .device(dec_device),
    .valid(dec_valid),
    .slave(dec_slave),
    .card(dec_card),
    .limit(dec_limit)
  );

  // state decodes shared by the sequencing and the output registers
  wire in_wait = (state == boot_select_pkg::st_wait);
  wire in_load = (state == boot_select_pkg::st_load);
  wire in_probe = (state == boot_select_pkg::st_probe);
  wire in_run = (state == boot_select_pkg::st_run);
  wire enter_load = (next_state == boot_select_pkg::st_load);
  wire enter_run = (next_state == boot_select_pkg::st_run);
  wire enter_failed = (next_state == boot_select_pkg::st_failed);
  wire enter_hold = (next_state == boot_select_pkg::st_hold);

  // error sources merged into one load failure
  wire load_error = err_header | err_copy | err_power | err_integrity | err_command;  // [RL8]
  wire test_mode = (boot_mode == boot_select_pkg::MODE_TEST_ACCESS);
  wire error_phase = in_load || (in_run && !booted);
  wire take_error = error_phase && load_error;
  wire strap_ready = (settle == boot_select_pkg::STRAP_SETTLE);
  wire at_limit = (pos >= dec_limit);  // [RL22]
  wire search_stop = in_probe && at_limit;  // [RL22]
  wire miss = in_wait && probe_done && !probe_header_ok;
  wire hit = in_wait && probe_done && probe_header_ok;
  wire can_fallback = dec_valid && !dec_slave;  // [RL9]

  // secondary request checks
  wire meta_named = meta_valid && (meta_secondary != 4'(boot_select_pkg::dev_none));  // [RL12]
  wire meta_same = meta_named && (meta_secondary == primary_device);  // [RL12]
  wire meta_ok = meta_named && !meta_same && in_run;
  // secondary kinds that need their own follow-up
  wire meta_pcie = (meta_secondary == 4'(boot_select_pkg::dev_pcie));
  wire meta_usb = (meta_secondary == 4'(boot_select_pkg::dev_usb));

  // flash offset is position times 32k; lower device only while booting [RL20] [RL10]
  wire [boot_select_pkg::OFFSET_W-1:0] pos_offset =
    boot_select_pkg::OFFSET_W'({pos, {boot_select_pkg::STEP_SHIFT{1'b0}}});

  // next retry index: error increment wins over a software rewrite
  assign next_index = take_error && !test_mode ? image_retry_index + PW'(1) :  // [RL6]
                      retry_write ? retry_wdata :  // [RL17]
                      hit ? pos[PW-1:0] :
                      image_retry_index;

  // next search position
  assign next_pos = (state == boot_select_pkg::st_capture) ? {1'b0, image_retry_index} :
                    miss ? pos + (PW+1)'(1) :
                    pos;

  // controller sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      boot_select_pkg::st_capture: begin
        if (strap_ready || booted) begin
          if (!dec_valid) begin
            next_state = boot_select_pkg::st_failed;  // [RL21]
          end else if (dec_slave) begin
            next_state = boot_select_pkg::st_load;  // [RL3]
          end else begin
            next_state = boot_select_pkg::st_probe;
          end
        end
      end
      boot_select_pkg::st_probe: begin
        next_state = at_limit ? boot_select_pkg::st_failed : boot_select_pkg::st_wait;  // [RL22]
      end
      boot_select_pkg::st_wait: begin
        if (hit) begin
          next_state = boot_select_pkg::st_load;
        end else if (miss) begin
          next_state = boot_select_pkg::st_probe;
        end
      end
      boot_select_pkg::st_load: begin
        if (load_error) begin
          next_state = test_mode ? boot_select_pkg::st_hold : boot_select_pkg::st_capture;  // [RL7]
        end else if (fw_copy_done) begin
          next_state = boot_select_pkg::st_run;  // [RL11]
        end
      end
      boot_select_pkg::st_run: begin
        if (take_error) begin
          next_state = test_mode ? boot_select_pkg::st_hold : boot_select_pkg::st_capture;  // [RL6] [RL7]
        end
      end
      boot_select_pkg::st_hold: next_state = boot_select_pkg::st_hold;
      boot_select_pkg::st_failed: next_state = boot_select_pkg::st_failed;
    endcase
  end

  // two-flop pin synchroniser, not reset
  always_ff @(posedge clk) begin
    pin_meta <= mode_pins;
    pin_sync <= pin_meta;
  end

  // strap capture once after reset release [RL19]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settle <= '0;
      boot_mode <= '0;
    end else if (!strap_ready) begin
      settle <= settle + 2'h1;
      if (settle == boot_select_pkg::STRAP_SETTLE - 2'h1) begin
        boot_mode <= pin_sync;  // [RL19]
      end
    end
  end

  // state, search position and retry index
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= boot_select_pkg::st_capture;
      pos <= '0;
      image_retry_index <= '0;
      booted <= 1'b0;
    end else begin
      state <= next_state;
      pos <= next_pos;
      image_retry_index <= next_index;
      if (boot_complete && state == boot_select_pkg::st_run) begin
        booted <= 1'b1;
      end
    end
  end

  // decoded mode presented on registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primary_device <= 4'(boot_select_pkg::dev_none);
      slave_boot <= 1'b0;
      fallback_enable <= 1'b0;
    end else if (strap_ready) begin
      primary_device <= 4'(dec_device);  // [RL1] [RL2]
      slave_boot <= dec_slave;  // [RL3]
      fallback_enable <= can_fallback;  // [RL9]
    end
  end

  // header probe requests: block reads only, never mapped fetch [RL18]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      probe_req <= 1'b0;
      probe_offset <= '0;
      probe_file <= '0;
    end else begin
      probe_req <= in_probe && !at_limit;
      if (in_probe) begin
        probe_offset <= dec_card ? '0 : pos_offset;  // [RL20] [RL4] [RL5]
        probe_file <= dec_card ? pos[PW-1:0] : '0;  // [RL5]
      end
    end
  end

  // loader firmware copy and processor release [RL11]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fw_copy_req <= 1'b0;
      loader_release <= 1'b0;
    end else begin
      fw_copy_req <= enter_load;  // [RL11]
      loader_release <= enter_run;  // [RL11]
    end
  end

  // soft reset pulse and failure flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_system_reset <= 1'b0;
      boot_error <= 1'b0;
      search_exhausted <= 1'b0;
    end else begin
      soft_system_reset <= take_error && !test_mode;  // [RL6] [RL7]
      boot_error <= enter_failed || enter_hold;  // [RL21]
      if (search_stop) begin
        search_exhausted <= 1'b1;  // [RL22]
      end
    end
  end

  // upper stacked flash reachable only after boot completes [RL10]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upper_flash_enable <= 1'b0;
    end else begin
      upper_flash_enable <= booted;  // [RL10]
    end
  end

  // secondary source steering
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      secondary_start <= 1'b0;
      secondary_reject <= 1'b0;
      secondary_device <= 4'(boot_select_pkg::dev_none);
      secondary_header_expected <= 1'b0;
      pcie_endpoint_init <= 1'b0;
      secondary_load_addr <= '0;
    end else begin
      secondary_start <= meta_ok;  // [RL12]
      secondary_reject <= meta_same && in_run;  // [RL12]
      pcie_endpoint_init <= meta_ok && meta_pcie;  // [RL15]
      secondary_header_expected <= 1'b0;  // [RL13]
      if (meta_ok) begin
        secondary_device <= meta_secondary;  // [RL16]
        secondary_load_addr <= meta_usb ? boot_select_pkg::USB_STAGE_ADDR : '0;  // [RL14]
      end
    end
  end
endmodule // boot_source_select_fallback
`default_nettype wire

// >>> verilog/boot_select_pkg.sv
`default_nettype none
package boot_select_pkg;

  // boot device identities, primary and secondary
  typedef enum logic [3:0] {
    dev_none = 4'h0,
    dev_test_access = 4'h1,
    dev_second_card = 4'h2,
    dev_octal_flash = 4'h3,
    dev_quad24 = 4'h4,
    dev_quad32 = 4'h5,
    dev_sd0_v3 = 4'h6,
    dev_sd1_v2 = 4'h7,
    dev_sd1_v3 = 4'h8,
    dev_parallel_slave = 4'h9,
    dev_first_card = 4'hA,
    dev_usb = 4'hB,
    dev_pcie = 4'hC,
    dev_ethernet = 4'hD
  } dev_e;

  // boot mode pin patterns
  localparam logic [3:0] MODE_TEST_ACCESS = 4'h0;
  localparam logic [3:0] MODE_QUAD24 = 4'h1;
  localparam logic [3:0] MODE_QUAD32 = 4'h2;
  localparam logic [3:0] MODE_SD0_V3 = 4'h3;
  localparam logic [3:0] MODE_SD1_V2 = 4'h5;
  localparam logic [3:0] MODE_SECOND_CARD = 4'h6;
  localparam logic [3:0] MODE_OCTAL = 4'h8;
  localparam logic [3:0] MODE_PARALLEL = 4'hA;
  localparam logic [3:0] MODE_SD1_V3 = 4'hE;

  // search geometry: 32k byte step, limits in megabits
  localparam int STEP_SHIFT = 15;
  localparam int POS_W = 16;
  localparam int OFFSET_W = 32;
  localparam longint LIMIT_OCTAL_MBIT = 8192;
  localparam longint LIMIT_Q24_MBIT = 128;
  localparam longint LIMIT_Q24_DP_MBIT = 256;
  localparam longint LIMIT_Q32_MBIT = 4096;
  localparam longint LIMIT_Q32_DP_MBIT = 8192;
  localparam longint CARD_FILE_COUNT = 8191;

  // limit expressed as a count of search positions
  function automatic logic [POS_W:0] mbit_to_positions(input longint mbit);
    longint bytes;
    bytes = mbit * 131072;
    return (POS_W+1)'(bytes >> STEP_SHIFT);
  endfunction

  localparam logic [POS_W:0] POS_OCTAL = mbit_to_positions(LIMIT_OCTAL_MBIT);
  localparam logic [POS_W:0] POS_Q24 = mbit_to_positions(LIMIT_Q24_MBIT);
  localparam logic [POS_W:0] POS_Q24_DP = mbit_to_positions(LIMIT_Q24_DP_MBIT);
  localparam logic [POS_W:0] POS_Q32 = mbit_to_positions(LIMIT_Q32_MBIT);
  localparam logic [POS_W:0] POS_Q32_DP = mbit_to_positions(LIMIT_Q32_DP_MBIT);
  localparam logic [POS_W:0] POS_CARD = (POS_W+1)'(CARD_FILE_COUNT);

  // fixed staging address for usb secondary images
  localparam logic [OFFSET_W-1:0] USB_STAGE_ADDR = 32'h0500_0000;

  // cycles the pin synchroniser needs before the strap is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // controller states, gray along the usual path
  typedef enum logic [2:0] {
    st_capture = 3'b000,
    st_probe = 3'b001,
    st_wait = 3'b011,
    st_load = 3'b010,
    st_run = 3'b110,
    st_hold = 3'b100,
    st_failed = 3'b101
  } state_e;

endpackage
`default_nettype wire

// >>> verilog/boot_mode_decode.sv
`timescale 1ns/10ps
`default_nettype none
module boot_mode_decode (
  input wire logic [3:0] mode,
  input wire logic dual_parallel,
  output boot_select_pkg::dev_e device,
  output logic valid,
  output logic slave,
  output logic card,
  output logic [boot_select_pkg::POS_W:0] limit
);
  wire is_octal = (mode == boot_select_pkg::MODE_OCTAL);
  wire is_q24 = (mode == boot_select_pkg::MODE_QUAD24);
  wire is_q32 = (mode == boot_select_pkg::MODE_QUAD32);
  wire is_test = (mode == boot_select_pkg::MODE_TEST_ACCESS);
  wire is_par = (mode == boot_select_pkg::MODE_PARALLEL);
  wire is_card1 = (mode == boot_select_pkg::MODE_SECOND_CARD);
  wire is_sd0 = (mode == boot_select_pkg::MODE_SD0_V3);
  wire is_sd1a = (mode == boot_select_pkg::MODE_SD1_V2);
  wire is_sd1b = (mode == boot_select_pkg::MODE_SD1_V3);

  // pattern to device; first card controller has no pattern at all [RL16]
  assign device = is_test ? boot_select_pkg::dev_test_access :  // [RL1]
                  is_card1 ? boot_select_pkg::dev_second_card :
                  is_octal ? boot_select_pkg::dev_octal_flash :
                  is_q24 ? boot_select_pkg::dev_quad24 :  // [RL2]
                  is_q32 ? boot_select_pkg::dev_quad32 :
                  is_sd0 ? boot_select_pkg::dev_sd0_v3 :
                  is_sd1a ? boot_select_pkg::dev_sd1_v2 :
                  is_sd1b ? boot_select_pkg::dev_sd1_v3 :
                  is_par ? boot_select_pkg::dev_parallel_slave :
                  boot_select_pkg::dev_none;
  // unlisted pattern selects nothing [RL21]
  assign valid = (device != boot_select_pkg::dev_none);
  assign slave = is_test | is_par;  // [RL3]
  assign card = is_card1 | is_sd0 | is_sd1a | is_sd1b;

  // per-mode search limit in positions [RL4] [RL5]
  assign limit = is_octal ? boot_select_pkg::POS_OCTAL :
                 is_q24 ? (dual_parallel ? boot_select_pkg::POS_Q24_DP : boot_select_pkg::POS_Q24) :
                 is_q32 ? (dual_parallel ? boot_select_pkg::POS_Q32_DP : boot_select_pkg::POS_Q32) :
                 card ? boot_select_pkg::POS_CARD :
                 '0;
endmodule // boot_mode_decode
`default_nettype wire

// >>> dv/boot_select_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module boot_select_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] boot_mode,
  input wire logic [3:0] primary_device,
  input wire logic slave_boot,
  input wire logic fallback_enable,
  input wire logic probe_req,
  input wire logic [31:0] probe_offset,
  input wire logic fw_copy_req,
  input wire logic loader_release,
  input wire logic soft_system_reset,
  input wire logic [15:0] image_retry_index,
  input wire logic boot_error,
  input wire logic search_exhausted,
  input wire logic upper_flash_enable,
  input wire logic boot_complete,
  input wire logic secondary_start,
  input wire logic [3:0] secondary_device,
  input wire logic pcie_endpoint_init,
  input wire logic [31:0] secondary_load_addr
);
  // expected device code for each strap pattern
  localparam logic [3:0] MAP [16] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h0, 4'h7, 4'h2, 4'h0,
    4'h3, 4'h0, 4'h9, 4'h0, 4'h0, 4'h0, 4'h8, 4'h0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // decode, fallback, search, loader, stacked flash and secondary checks
  a_strap_map: assert property (primary_device != 4'h0 |-> primary_device == MAP[boot_mode])
    else $error("device code does not match strap");
  a_slave_flags: assert property ((primary_device == 4'h1 || primary_device == 4'h9) |->
    slave_boot && !fallback_enable) else $error("slave port flags wrong");
  a_retry_bump: assert property (soft_system_reset |-> image_retry_index == $past(image_retry_index) + 16'h1)
    else $error("retry index did not step with soft reset");
  a_debug_hold: assert property (boot_mode == 4'h0 |-> !soft_system_reset)
    else $error("soft reset in debug mode");
  a_upper_late: assert property ($rose(upper_flash_enable) |-> $past(boot_complete, 2))
    else $error("upper flash enabled before completion");
  a_copy_first: assert property ($rose(loader_release) |-> $past(fw_copy_req))
    else $error("release without firmware copy");
  a_sec_differs: assert property (secondary_start |-> secondary_device != primary_device)
    else $error("secondary equals primary");
  a_usb_stage: assert property ((secondary_start && secondary_device == 4'hB) |->
    ##[0:1] (secondary_load_addr == 32'h0500_0000)) else $error("usb staging address wrong");
  a_pcie_cause: assert property (pcie_endpoint_init |-> secondary_start && secondary_device == 4'hC)
    else $error("endpoint init without pcie secondary");
  a_step_align: assert property (probe_req |-> probe_offset[14:0] == 15'h0)
    else $error("probe offset off step");
  a_exhaust_fail: assert property ($rose(search_exhausted) |-> ##[0:1] boot_error)
    else $error("exhausted search without error");
endmodule // boot_select_monitor
bind boot_source_select_fallback boot_select_monitor boot_select_monitor_inst (.clk, .sys_rst, .boot_mode,
  .primary_device, .slave_boot, .fallback_enable, .probe_req, .probe_offset, .fw_copy_req, .loader_release,
  .soft_system_reset, .image_retry_index, .boot_error, .search_exhausted, .upper_flash_enable, .boot_complete,
  .secondary_start, .secondary_device, .pcie_endpoint_init, .secondary_load_addr);
`default_nettype wire

// >>> dv/boot_media_model.sv
`timescale 1ns/10ps
`default_nettype none
module boot_media_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [15:0] good_pos,
  input wire logic probe_req,
  input wire logic [31:0] probe_offset,
  input wire logic [15:0] probe_file,
  input wire logic fw_copy_req,
  output logic probe_done,
  output logic probe_header_ok,
  output logic fw_copy_done
);
  logic [2:0] pwait = 3'h0;
  logic [2:0] cwait = 3'h0;
  logic hit = 1'b0;
  logic seen = 1'b0;
  initial begin
    probe_done = 1'b0;
    probe_header_ok = 1'b0;
    fw_copy_done = 1'b0;
  end
  // header probe answer, valid only at the one wanted position
  always @(posedge clk) begin
    probe_done <= 1'b0;
    if (probe_done) probe_header_ok <= ~probe_header_ok; // released line shows no stale level
    if (probe_req) begin
      pwait <= slow ? 3'h3 : 3'h1;
      hit <= (probe_offset[30:15] | probe_file) == good_pos;
    end else if (pwait == 3'h1) begin
      probe_done <= 1'b1;
      probe_header_ok <= hit;
      pwait <= 3'h0;
    end else if (pwait != 3'h0) pwait <= pwait - 3'h1;
  end
  // firmware copy answer, one pulse per request
  always @(posedge clk) begin
    fw_copy_done <= 1'b0;
    if (!fw_copy_req) begin
      seen <= 1'b0;
      cwait <= slow ? 3'h4 : 3'h1;
    end else if (!seen) begin
      if (cwait == 3'h0) begin
        fw_copy_done <= 1'b1;
        seen <= 1'b1;
      end else cwait <= cwait - 3'h1;
    end
  end
endmodule // boot_media_model
`default_nettype wire

// >>> dv/boot_source_select_fallback_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module boot_source_select_fallback_tb_top;
  logic clk = 0, sys_rst = 1, dual_parallel = 0, retry_write = 0, meta_valid = 0, boot_complete = 0, slow = 0;
  logic [3:0] mode_pins = 4'h0, meta_secondary = 4'h0, boot_mode, primary_device, secondary_device;
  logic [4:0] errs = 5'h0;
  logic [15:0] retry_wdata = 16'h0, good_pos = 16'h0, first_pos, image_retry_index, probe_file;
  logic [31:0] probe_offset, secondary_load_addr;
  logic probe_done, probe_header_ok, fw_copy_done, slave_boot, fallback_enable, probe_req, fw_copy_req,
    loader_release, soft_system_reset, boot_error, search_exhausted, upper_flash_enable, secondary_start,
    secondary_reject, secondary_header_expected, pcie_endpoint_init;
  int miscompares = 0, checks = 0, probes = 0, resets = 0, i, n;
  // strap, device, slave, fallback, error
  logic [11:0] rows [10] = '{12'h018, 12'h624, 12'h834, 12'h144, 12'h254, 12'h364, 12'h574, 12'hE84,
    12'hA98, 12'h402};
  int lim [6] = '{512, 1024, 16384, 32768, 32768, 8191};
  logic [3:0] lmode [6] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h8, 4'h6};
  always #12.5 clk = ~clk;
  boot_source_select_fallback boot_source_select_fallback_inst (.clk, .sys_rst, .mode_pins, .dual_parallel,
    .probe_done, .probe_header_ok, .fw_copy_done, .err_header(errs[0]), .err_copy(errs[1]),
    .err_power(errs[2]), .err_integrity(errs[3]), .err_command(errs[4]), .retry_write, .retry_wdata,
    .meta_valid, .meta_secondary, .boot_complete, .boot_mode, .primary_device, .slave_boot, .fallback_enable,
    .probe_req, .probe_offset, .probe_file, .fw_copy_req, .loader_release, .soft_system_reset,
    .image_retry_index, .boot_error, .search_exhausted, .upper_flash_enable, .secondary_start,
    .secondary_reject, .secondary_device, .secondary_header_expected, .pcie_endpoint_init, .secondary_load_addr);
  boot_media_model boot_media_model_inst (.clk, .slow, .good_pos, .probe_req, .probe_offset, .probe_file,
    .fw_copy_req, .probe_done, .probe_header_ok, .fw_copy_done);
  // probe and soft reset counts
  always @(posedge clk) begin
    if (probe_req === 1'b1 && probes == 0) first_pos <= probe_offset[30:15] | probe_file;
    if (probe_req === 1'b1) probes <= probes + 1;
    if (soft_system_reset === 1'b1) resets <= resets + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return loader_release;
      1: return soft_system_reset;
      2: return search_exhausted;
      3: return secondary_start | secondary_reject;
      default: return upper_flash_enable;
    endcase
  endfunction
  // bounded wait, polled at the falling edge
  task automatic wait_for(input int s, input int bound);
    int k;
    for (k = 0; k < bound; k++) begin
      @(negedge clk);
      if (sig(s) === 1'b1) return;
    end
    chk(32'h0, 32'h1);
    report_and_stop;
  endtask
  task automatic boot(input logic [3:0] m, input logic d);
    @(posedge clk);
    sys_rst <= 1'b1;
    mode_pins <= m;
    dual_parallel <= d;
    good_pos <= 16'h0;
    slow <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({boot_mode, primary_device, image_retry_index}, 32'h0);
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_err(input int k);
    @(posedge clk);
    errs <= 5'h1 << k;
    @(posedge clk);
    errs <= 5'h0;
  endtask
  // run length guard
  initial begin
    #2500000;
    chk(32'h0, 32'h1);
    report_and_stop;
  end
  initial begin
    // strap decode table
    for (i = 0; i < 10; i++) begin
      boot(rows[i][11:8], 1'b0);
      chk(boot_mode, rows[i][11:8]);
      chk(primary_device, rows[i][7:4]);
      chk({slave_boot, fallback_enable, boot_error}, rows[i][3:1]);
      $display("decode row %0d done", i);
    end
    // limits, every error kind, runtime index rewrite
    for (i = 0; i < 6; i++) begin
      boot(lmode[i], i == 1 || i == 3);
      wait_for(0, 40);
      @(posedge clk);
      retry_write <= 1'b1;
      retry_wdata <= 16'(lim[i] - 3);
      slow <= i[0];
      @(posedge clk);
      retry_write <= 1'b0;
      good_pos <= 16'hFFFF;
      @(negedge clk);
      probes = 0;
      resets = 0;
      pulse_err(i % 5);
      wait_for(1, 4);
      chk(image_retry_index, lim[i] - 2);
      wait_for(2, 60);
      chk(probes, 2);
      chk(first_pos, lim[i] - 2);
      chk({resets[30:0], boot_error}, 32'h3);
      $display("limit row %0d done", i);
    end
    // debug mode keeps the system up on errors
    boot(4'h0, 1'b0);
    wait_for(0, 40);
    resets = 0;
    pulse_err(1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({resets[14:0], image_retry_index, boot_error}, 32'h1);
    $display("debug mode test done");
    // secondary sources, then completion
    boot(4'h8, 1'b0);
    wait_for(0, 40);
    for (i = 0; i < 3; i++) begin
      n = (i == 0) ? 11 : (i == 1) ? 12 : 3;
      @(posedge clk);
      meta_valid <= 1'b1;
      meta_secondary <= 4'(n);
      @(posedge clk);
      meta_valid <= 1'b0;
      wait_for(3, 4);
      chk({secondary_start, secondary_reject, pcie_endpoint_init}, {n != 3, n == 3, n == 12});
      chk(secondary_header_expected, 1'b0);
      if (n == 11) chk(secondary_load_addr, 32'h0500_0000);
    end
    @(posedge clk);
    boot_complete <= 1'b1;
    @(posedge clk);
    boot_complete <= 1'b0;
    wait_for(4, 4);
    chk(upper_flash_enable, 1'b1);
    $display("secondary test done");
    report_and_stop;
  end
endmodule // boot_source_select_fallback_tb_top
`default_nettype wire
